// ---- logic/plc_integrator.sv ----
// integration timer spanning one whole mains cycle
`timescale 1ns/10ps
`include "scan_measure_regs.svh"
module plc_integrator #(
    parameter int unsigned PERIOD_LOW = `PERIOD_LOW_CYC,
    parameter int unsigned PERIOD_HIGH = `PERIOD_HIGH_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic use_low,
    output logic done
);
    logic [21:0] count_reg; // cycles left in the window
    logic [21:0] count_next;
    logic busy_reg;
    logic busy_next;
    logic done_reg;
    logic done_next;
    // period latched at start so a mid-run change cannot cut the window
    always_comb begin
        count_next = count_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (start && !busy_reg) begin
            busy_next = 1'b1;
            count_next = use_low ? 22'(PERIOD_LOW - 1)
                                 : 22'(PERIOD_HIGH - 1);
        end else if (busy_reg) begin
            if (count_reg == 22'h00_0000) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end else begin
                count_next = count_reg - 22'h00_0001;
            end
        end
    end
    // register stage
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            count_reg <= 22'h00_0000;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end
    assign done = done_reg;
endmodule

// ---- logic/scan_measure_handshake.sv ----
// trigger / complete handshake and mains reference setting
`timescale 1ns/10ps
`include "scan_measure_regs.svh"
// Overview of operation
// - trigger starts one measurement
// - finished measurement pulses complete line
// - handshake runs without controller, fast enough
// - bus is complete, trigger and ground
// - max selector sets 60 Hz
// - default 60 Hz, kept, changed by command
// - query returns setting or limits
// - only 50 or 60; min sets 50
// - integration spans whole mains cycles
module scan_measure_handshake #(
    parameter int unsigned PERIOD_LOW = `PERIOD_LOW_CYC,
    parameter int unsigned PERIOD_HIGH = `PERIOD_HIGH_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic bus_connected,
    input wire logic trigger_in,
    output logic complete_out,
    output logic measuring,
    input wire scan_measure_pkg::freq_cmd_t cmd,
    output scan_measure_pkg::freq_resp_t resp,
    input wire logic [7:0] nv_freq_in,
    input wire logic nv_valid,
    output logic nv_write,
    output logic [7:0] nv_freq_out
);
    typedef enum logic [1:0] {IDLE, MEASURE, COMPLETE} state_t;
    state_t state_reg; // handshake state
    state_t state_next;
    logic trig_reg; // previous trigger level for edge detect
    logic trig_next;
    logic [4:0] pulse_reg; // complete pulse length counter
    logic [4:0] pulse_next;
    logic complete_reg;
    logic complete_next;
    logic measuring_reg;
    logic measuring_next;
    logic [7:0] freq_reg; // live mains setting
    logic [7:0] freq_next;
    logic loaded_reg; // nv copy taken once after reset
    logic loaded_next;
    scan_measure_pkg::freq_resp_t resp_reg;
    scan_measure_pkg::freq_resp_t resp_next;
    logic nv_write_reg;
    logic nv_write_next;
    logic [7:0] nv_out_reg;
    logic [7:0] nv_out_next;
    logic start;
    logic done;
    logic trig_edge;

    assign trig_edge = trigger_in && !trig_reg;
    assign start = (state_reg == IDLE) && trig_edge && bus_connected;

    plc_integrator #(
        .PERIOD_LOW(PERIOD_LOW),
        .PERIOD_HIGH(PERIOD_HIGH)
    ) u_integ (
        .clk(clk),
        .reset_n(reset_n),
        .start(start),
        .use_low(freq_reg == `FREQ_LOW_HZ),
        .done(done)
    );

    // handshake: rising trigger edge runs one measurement, then pulses
    always_comb begin
        state_next = state_reg;
        trig_next = trigger_in;
        pulse_next = pulse_reg;
        complete_next = 1'b0;
        measuring_next = 1'b0;
        unique case (state_reg)
            IDLE: begin
                // edges ignored unless the digital bus is cabled
                if (start) begin
                    state_next = MEASURE;
                    measuring_next = 1'b1;
                end
            end
            MEASURE: begin
                // further trigger edges are dropped here
                measuring_next = 1'b1;
                if (done) begin
                    state_next = COMPLETE;
                    measuring_next = 1'b0;
                    complete_next = 1'b1;
                    pulse_next = 5'(`COMPLETE_PULSE_CYC - 1);
                end
            end
            COMPLETE: begin
                if (pulse_reg == 5'h00) begin
                    state_next = IDLE;
                end else begin
                    complete_next = 1'b1;
                    pulse_next = pulse_reg - 5'h01;
                end
            end
        endcase
    end

    // mains reference: nv restore, set and query commands
    always_comb begin
        freq_next = freq_reg;
        loaded_next = loaded_reg;
        resp_next = '0;
        nv_write_next = 1'b0;
        nv_out_next = nv_out_reg;
        if (!loaded_reg && nv_valid) begin
            loaded_next = 1'b1;
            // a corrupt stored value falls back to the shipped default
            if (nv_freq_in == `FREQ_LOW_HZ || nv_freq_in == `FREQ_HIGH_HZ)
                freq_next = nv_freq_in;
        end else if (cmd.valid) begin
            resp_next.valid = 1'b1;
            if (cmd.query) begin
                unique case (cmd.sel)
                    scan_measure_pkg::SEL_MIN: resp_next.value = `FREQ_LOW_HZ;
                    scan_measure_pkg::SEL_MAX:
                        resp_next.value = `FREQ_HIGH_HZ;
                    default: resp_next.value = freq_reg;
                endcase
            end else begin
                unique case (cmd.sel)
                    scan_measure_pkg::SEL_MIN: freq_next = `FREQ_LOW_HZ;
                    scan_measure_pkg::SEL_MAX: freq_next = `FREQ_HIGH_HZ;
                    default: begin
                        if (cmd.value == `FREQ_LOW_HZ ||
                            cmd.value == `FREQ_HIGH_HZ)
                            freq_next = cmd.value;
                        else
                            resp_next.error = 1'b1;
                    end
                endcase
                nv_write_next = !resp_next.error;
                nv_out_next = freq_next;
                resp_next.value = freq_next;
            end
        end
    end

    // register stage
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= IDLE;
            trig_reg <= 1'b0;
            pulse_reg <= 5'h00;
            complete_reg <= 1'b0;
            measuring_reg <= 1'b0;
            freq_reg <= `FREQ_RESET_HZ;
            loaded_reg <= 1'b0;
            resp_reg <= '0;
            nv_write_reg <= 1'b0;
            nv_out_reg <= `FREQ_RESET_HZ;
        end else begin
            state_reg <= state_next;
            trig_reg <= trig_next;
            pulse_reg <= pulse_next;
            complete_reg <= complete_next;
            measuring_reg <= measuring_next;
            freq_reg <= freq_next;
            loaded_reg <= loaded_next;
            resp_reg <= resp_next;
            nv_write_reg <= nv_write_next;
            nv_out_reg <= nv_out_next;
        end
    end

    assign complete_out = complete_reg;
    assign measuring = measuring_reg;
    assign resp = resp_reg;
    assign nv_write = nv_write_reg;
    assign nv_freq_out = nv_out_reg;

    AST_START_MEAS: assert property (
        @(posedge clk) disable iff (!reset_n) start |=> measuring)
        else $error("trigger did not start measurement");
    AST_COMPLETE_AFTER_DONE: assert property (
        @(posedge clk) disable iff (!reset_n) done |=> complete_out)
        else $error("no complete after measurement");
    AST_NO_IDLE_PULSE: assert property (
        @(posedge clk) disable iff (!reset_n)
        $rose(complete_out) |-> $past(done))
        else $error("complete pulse without measurement");
    AST_UNCONNECTED: assert property (
        @(posedge clk) disable iff (!reset_n)
        (!bus_connected && state_reg == IDLE) |=> !measuring)
        else $error("measured with bus disconnected");
    AST_MAX_SET: assert property (
        @(posedge clk) disable iff (!reset_n)
        (cmd.valid && !cmd.query && cmd.sel == scan_measure_pkg::SEL_MAX
         && loaded_reg) |=> freq_reg == `FREQ_HIGH_HZ)
        else $error("max did not select 60");
    AST_LEGAL_FREQ: assert property (
        @(posedge clk) disable iff (!reset_n)
        freq_reg == `FREQ_LOW_HZ || freq_reg == `FREQ_HIGH_HZ)
        else $error("illegal mains setting");
    AST_QUERY_MIN: assert property (
        @(posedge clk) disable iff (!reset_n)
        (cmd.valid && cmd.query && cmd.sel == scan_measure_pkg::SEL_MIN
         && loaded_reg) |=> resp.value == `FREQ_LOW_HZ)
        else $error("min query wrong");
    AST_STABLE_FREQ: assert property (
        @(posedge clk) disable iff (!reset_n)
        (!cmd.valid && loaded_reg) |=> $stable(freq_reg))
        else $error("setting changed without command");
    // a running measurement is only ended by the integrator, so a stray
    // trigger edge cannot restart or cut the window
    AST_MEAS_HOLD: assert property (
        @(posedge clk) disable iff (!reset_n)
        (measuring && !done) |=> measuring)
        else $error("measurement cut short");
    // every command taken after the restore is answered next cycle
    AST_CMD_ANSWER: assert property (
        @(posedge clk) disable iff (!reset_n)
        (cmd.valid && loaded_reg) |=> resp.valid)
        else $error("command not answered");
    // only a legal setting may ever reach the stored copy
    AST_NV_LEGAL: assert property (
        @(posedge clk) disable iff (!reset_n) nv_write |->
        (nv_freq_out == `FREQ_LOW_HZ || nv_freq_out == `FREQ_HIGH_HZ))
        else $error("illegal value stored");
    // an out-of-range set value is refused and never stored
    AST_REFUSE_BAD: assert property (
        @(posedge clk) disable iff (!reset_n)
        (cmd.valid && !cmd.query && cmd.sel == scan_measure_pkg::SEL_VALUE
         && loaded_reg && cmd.value != `FREQ_LOW_HZ
         && cmd.value != `FREQ_HIGH_HZ) |=> (resp.error && !nv_write))
        else $error("bad setting accepted");
endmodule

// ---- logic/scan_measure_pkg.sv ----
// types for the scan measure handshake block
package scan_measure_pkg;
    typedef enum logic [1:0] {
        SEL_VALUE,
        SEL_MIN,
        SEL_MAX
    } freq_sel_t;
    typedef struct packed {
        logic valid;
        logic query;
        freq_sel_t sel;
        logic [7:0] value;
    } freq_cmd_t;
    typedef struct packed {
        logic valid;
        logic error;
        logic [7:0] value;
    } freq_resp_t;
endpackage

// ---- logic/scan_measure_regs.svh ----
// constants for the scan measure handshake block
`ifndef SCAN_MEASURE_REGS_SVH
`define SCAN_MEASURE_REGS_SVH
`define CLK_FREQ_HZ 50000000
`define FREQ_LOW_HZ 8'h32
`define FREQ_HIGH_HZ 8'h3C
`define FREQ_RESET_HZ 8'h3C
`define PERIOD_LOW_CYC (`CLK_FREQ_HZ / 50)
`define PERIOD_HIGH_CYC (`CLK_FREQ_HZ / 60)
`define COMPLETE_PULSE_NS 500
`define COMPLETE_PULSE_CYC ((`COMPLETE_PULSE_NS + 19) / 20)
`endif

// ---- verification/mux_seq_model.sv ----
// channel sequencer model standing at the far end of the digital bus
`timescale 1ns/10ps
module mux_seq_model (
    input wire logic clk,
    input wire logic run,
    input wire logic chatter,
    input wire logic complete_in,
    output logic trigger_out,
    output int channel
);
    // trigger idles low; channel counts advances; one process owns both
    // one pass per channel: close, trigger, then wait for complete
    initial begin
        trigger_out = 1'b0;
        channel = 0;
        forever begin
            @(posedge clk);
            if (run) begin
                repeat (3) @(posedge clk); // channel settling time
                trigger_out <= 1'b1;
                repeat (2) @(posedge clk);
                trigger_out <= 1'b0;
                // stray edge mid measurement, only when asked for
                if (chatter) begin
                    repeat (8) @(posedge clk);
                    trigger_out <= 1'b1;
                    @(posedge clk);
                    trigger_out <= 1'b0;
                end
                // wait for the whole pulse so no edge is retaken early
                @(posedge clk iff complete_in);
                @(posedge clk iff !complete_in);
                channel <= channel + 1;
            end
        end
    end
endmodule

// ---- verification/tb_top.sv ----
// testbench for the scan measure handshake block
`timescale 1ns/10ps
`include "scan_measure_regs.svh"
module tb_top;
    logic clk, reset_n, bus_connected, run, chatter, nv_valid;
    logic trigger, complete, measuring, nv_write;
    logic [7:0] nv_freq_in, nv_freq_out;
    int channel;
    scan_measure_pkg::freq_cmd_t cmd;
    scan_measure_pkg::freq_resp_t resp;
    int n_mismatch = 0;
    int tests_run = 0;
    // short integration periods keep the run brief
    scan_measure_handshake #(.PERIOD_LOW(50), .PERIOD_HIGH(60))
        i_scan_measure_handshake (.clk(clk), .reset_n(reset_n),
        .bus_connected(bus_connected), .trigger_in(trigger),
        .complete_out(complete), .measuring(measuring), .cmd(cmd),
        .resp(resp), .nv_freq_in(nv_freq_in), .nv_valid(nv_valid),
        .nv_write(nv_write), .nv_freq_out(nv_freq_out));
    mux_seq_model i_mux_seq_model (.clk(clk), .run(run),
        .chatter(chatter), .complete_in(complete),
        .trigger_out(trigger), .channel(channel));
    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // one comparison, counted; an ok of x or z counts as a mismatch
    task check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // one command, answer judged in the cycle it stands
    task do_cmd(input logic q, input scan_measure_pkg::freq_sel_t s,
                input logic [7:0] v, input logic err, input logic [7:0] ev);
        @(posedge clk);
        cmd <= '{1'b1, q, s, v};
        @(posedge clk);
        cmd <= '0;
        #1;
        check(resp.valid === 1'b1 && resp.error === err, "resp flags");
        check(err || resp.value === ev, "resp value");
        check(nv_write === (!q && !err), "store strobe");
        check(!nv_write || nv_freq_out === ev, "stored value");
    endtask
    // n channels scanned; delay and pulse width judged per channel
    task scan(input int n, input int per, input logic chat);
        int t, k0;
        k0 = channel;
        @(posedge clk);
        run <= 1'b1;
        chatter <= chat;
        repeat (n) begin
            t = 0;
            do begin @(posedge clk); t++; end while (!trigger && t < 100);
            repeat (2) @(posedge clk);
            check(measuring === 1'b1, "not measuring");
            t = 2;
            while (complete !== 1'b1 && t < 1000) begin
                @(posedge clk);
                t++;
            end
            check(t >= per + 1 && t <= per + 3, "complete delay");
            check(measuring === 1'b0, "busy at complete");
            t = 0;
            while (complete === 1'b1 && t < 100) begin
                @(posedge clk);
                t++;
            end
            check(t == `COMPLETE_PULSE_CYC, "pulse width");
        end
        run <= 1'b0;
        chatter <= 1'b0;
        repeat (2) @(posedge clk);
        check(channel == k0 + n, "channel advances");
    endtask
    // mid-run reset: the stored setting comes back, a corrupt one gives 60
    task reset_cycle(input logic [7:0] stored, input logic [7:0] ev);
        @(posedge clk);
        reset_n <= 1'b0;
        nv_valid <= 1'b0;
        nv_freq_in <= stored;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        nv_valid <= 1'b1;
        #1;
        check(nv_freq_out === 8'h3C && nv_write === 1'b0, "mid reset");
        do_cmd(1, scan_measure_pkg::SEL_VALUE, 0, 0, ev);
    endtask
    // with the bus unplugged a trigger must start nothing
    task idle_bus;
        int seen;
        seen = 0;
        @(posedge clk);
        bus_connected <= 1'b0;
        run <= 1'b1;
        repeat (300) begin
            @(posedge clk);
            if (measuring !== 1'b0 || complete !== 1'b0)
                seen++;
        end
        check(seen == 0, "handshake while unplugged");
    endtask
    // main sequence
    initial begin
        reset_n = 1'b0;
        bus_connected = 1'b1;
        run = 1'b0;
        chatter = 1'b0;
        nv_valid = 1'b0;
        nv_freq_in = 8'h32;
        cmd = '0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        check(nv_freq_out === 8'h3C && resp === '0 && complete === 1'b0
              && measuring === 1'b0, "reset values");
        @(posedge clk);
        nv_valid <= 1'b1;
        @(posedge clk);
        do_cmd(1, scan_measure_pkg::SEL_VALUE, 0, 0, 8'h32);
        do_cmd(1, scan_measure_pkg::SEL_MIN, 0, 0, 8'h32);
        do_cmd(1, scan_measure_pkg::SEL_MAX, 0, 0, 8'h3C);
        do_cmd(0, scan_measure_pkg::SEL_VALUE, 8'h37, 1, 0);
        do_cmd(0, scan_measure_pkg::SEL_MAX, 0, 0, 8'h3C);
        scan(3, 60, 0);
        do_cmd(0, scan_measure_pkg::SEL_MIN, 0, 0, 8'h32);
        scan(2, 50, 1);
        do_cmd(0, scan_measure_pkg::SEL_VALUE, 8'h3C, 0, 8'h3C);
        do_cmd(1, scan_measure_pkg::SEL_VALUE, 0, 0, 8'h3C);
        reset_cycle(8'h37, 8'h3C);
        reset_cycle(8'h32, 8'h32);
        idle_bus;
        end_of_test;
    end
    // watchdog: the tests need under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("mismatch at %0t: timeout", $time);
        end_of_test;
    end
endmodule
